// [ssp_pkg.sv]
`default_nettype none
package ssp_pkg;
	// clock and time base
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_US = 500; // half-millisecond time base
	localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
	localparam int STROBE_MS = 200; // speed strobe width
	localparam int STAGE_MS = 100; // gap between 4-digit stages
	localparam int OSC_STEP_MS = 10; // oscillation period per count
	localparam int WINDOW_MS = 10; // encoder speed window
	localparam int STROBE_TICKS = STROBE_MS * 1000 / TICK_US;
	localparam int STAGE_TICKS = STAGE_MS * 1000 / TICK_US;
	// half period per oscillation count, in ticks
	localparam int OSC_HALF_TICKS = OSC_STEP_MS * 1000 / TICK_US / 2;
	localparam int WINDOW_TICKS = WINDOW_MS * 1000 / TICK_US;
	localparam int WINDOWS_PER_MIN = 60_000 / WINDOW_MS;
	// limits
	localparam logic [13:0] SPEED_MAX = 14'd9999;
	localparam logic [11:0] DRIVE_FULL = 12'd4000; // 10 V in 2.5 mV steps
	localparam int TRIM_LIM = 2047;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RANGE1 = 8'h04; // ranges 1..4 at +4 steps
	localparam logic [7:0] OFS_RESID = 8'h14;
	localparam logic [7:0] OFS_ENC = 8'h18;
	localparam logic [7:0] OFS_SPEED = 8'h1c;
	localparam logic [7:0] OFS_CMD = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_POS = 8'h28;
	// field positions
	localparam int STAT_REFUSED_BIT = 26;
	localparam int RESID_OSC_LSB = 8;
	// reset values
	localparam logic [13:0] RANGE_RST = 14'h270f; // 9999
	localparam logic [7:0] RESID_LVL_RST = 8'h01;
	localparam logic [7:0] OSC_RST = 8'h00;
	localparam logic [13:0] ENC_RST = 14'h0000;
	// configuration bits, held in CTRL[6:0]
	typedef struct packed {
		logic count_direction_select;
		logic four_digit_code_enable;
		logic two_digit_code_enable;
		logic speed_change_strobe_enable;
		logic unipolar_select;
		logic drive_sign_select;
		logic residual_drive_enable;
	} ssp_ctrl_s;
	// spindle commands, held in CMD[7:0]
	typedef struct packed {
		logic [1:0] range_sel;
		logic range_change;
		logic threading_cmd;
		logic rigid_tap_cycle;
		logic orientation_cmd;
		logic spin_counterclockwise_cmd;
		logic spin_clockwise_cmd;
	} ssp_cmd_s;
	// codes for speeds 0..9
	localparam logic [7:0] LOW_CODE [10] = '{8'h00, 8'h20, 8'h26, 8'h29,
		8'h32, 8'h34, 8'h35, 8'h36, 8'h38, 8'h39};
	// lower bounds of codes 40..99
	localparam logic [13:0] BOUND [60] = '{14'd10, 14'd12, 14'd13, 14'd14,
		14'd16, 14'd18, 14'd20, 14'd23, 14'd25, 14'd28, 14'd32, 14'd36,
		14'd40, 14'd45, 14'd50, 14'd56, 14'd63, 14'd71, 14'd80, 14'd90,
		14'd100, 14'd112, 14'd125, 14'd140, 14'd160, 14'd180, 14'd200,
		14'd224, 14'd250, 14'd280, 14'd315, 14'd355, 14'd400, 14'd450,
		14'd500, 14'd560, 14'd630, 14'd710, 14'd800, 14'd900, 14'd1000,
		14'd1120, 14'd1250, 14'd1400, 14'd1600, 14'd1800, 14'd2000,
		14'd2240, 14'd2500, 14'd2800, 14'd3150, 14'd3550, 14'd4000,
		14'd4500, 14'd5000, 14'd5600, 14'd6300, 14'd7100, 14'd8000,
		14'd9000};
endpackage
`default_nettype wire

// [ssp_spindle_out.sv]
`default_nettype none
module ssp_spindle_out #(
	parameter int TICK_CYC = ssp_pkg::TICK_CYC // cycles per 0.5 ms
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic enc_a,
	input wire logic enc_b,
	output logic signed [15:0] drive_code,
	output logic [7:0] bcd_lines,
	output logic speed_strobe,
	output logic closed_loop
);
	// refused at elaboration: the tick prescaler is 16 bits wide
	if (TICK_CYC < 1 || TICK_CYC > 65535) begin : g_tick_chk
		$error("TICK_CYC out of range");
	end

	// bus and configuration state
	ssp_pkg::ssp_ctrl_s ctrl_r, ctrl_nxt;
	ssp_pkg::ssp_cmd_s cmd_r, cmd_nxt;
	logic [13:0] range_max_r [4];
	logic [13:0] range_max_nxt [4];
	logic [7:0] resid_lvl_r, resid_lvl_nxt;
	logic [7:0] osc_code_r, osc_code_nxt;
	logic [13:0] enc_lines_r, enc_lines_nxt;
	logic [13:0] prog_speed_r, prog_speed_nxt; // already clamped
	logic refused_r, refused_nxt; // sticky, write 1 clears
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic new_speed; // one-cycle pulse on speed write
	logic wr_en;
	logic refuse_ev;
	logic [15:0] pos_r, pos_nxt; // spindle position count
	logic [31:0] status;

	// taken only in the access cycle the slave has answered
	assign wr_en = psel & penable & pready_r & pwrite;
	assign new_speed = wr_en & (paddr == ssp_pkg::OFS_SPEED);
	// feedback-dependent commands with no encoder fitted
	assign refuse_ev = wr_en & (paddr == ssp_pkg::OFS_CMD) &
		(enc_lines_r == 14'h0000) & (|pwdata[4:2]);

	// bus decode, register writes and read mux
	always_comb begin
		ctrl_nxt = ctrl_r;
		cmd_nxt = cmd_r;
		range_max_nxt = range_max_r;
		resid_lvl_nxt = resid_lvl_r;
		osc_code_nxt = osc_code_r;
		enc_lines_nxt = enc_lines_r;
		prog_speed_nxt = prog_speed_r;
		refused_nxt = refused_r;
		// no wait state: ready rises in the first access cycle
		pready_nxt = psel & ~penable;
		pslverr_nxt = 1'b0;
		prdata_nxt = prdata_r;
		if (psel & ~penable) begin
			prdata_nxt = 32'h0000_0000;
			unique case (paddr)
				ssp_pkg::OFS_CTRL: prdata_nxt = {25'h0, ctrl_r};
				8'h04, 8'h08, 8'h0c, 8'h10:
					prdata_nxt = {18'h0, range_max_r[paddr[3:2] - 2'd1]};
				ssp_pkg::OFS_RESID: prdata_nxt = {16'h0, osc_code_r, resid_lvl_r};
				ssp_pkg::OFS_ENC: prdata_nxt = {18'h0, enc_lines_r};
				ssp_pkg::OFS_SPEED: prdata_nxt = {18'h0, prog_speed_r};
				ssp_pkg::OFS_CMD: prdata_nxt = {24'h0, cmd_r};
				ssp_pkg::OFS_STATUS: prdata_nxt = status;
				ssp_pkg::OFS_POS: prdata_nxt = {16'h0, pos_r};
				default: pslverr_nxt = 1'b1; // unmapped address
			endcase
		end
		if (wr_en) begin
			unique case (paddr)
				ssp_pkg::OFS_CTRL: ctrl_nxt = pwdata[6:0];
				8'h04, 8'h08, 8'h0c, 8'h10: begin
					// limits above 9999 are held at 9999
					range_max_nxt[paddr[3:2] - 2'd1] =
						(pwdata[15:0] > 16'd9999) ? ssp_pkg::SPEED_MAX :
						pwdata[13:0];
				end
				ssp_pkg::OFS_RESID: begin
					// code 0 is outside 1..255, kept at the smallest step
					resid_lvl_nxt = (pwdata[7:0] == 8'h00) ? 8'h01 :
						pwdata[7:0];
					osc_code_nxt = pwdata[15:8];
				end
				ssp_pkg::OFS_ENC: enc_lines_nxt =
					(pwdata[15:0] > 16'd9999) ? ssp_pkg::SPEED_MAX :
					pwdata[13:0];
				ssp_pkg::OFS_SPEED: prog_speed_nxt =
					(pwdata[15:0] > 16'd9999) ? ssp_pkg::SPEED_MAX :
					pwdata[13:0];
				ssp_pkg::OFS_CMD: begin
					cmd_nxt = pwdata[7:0];
					// refused commands are dropped, the rest stand
					if (enc_lines_r == 14'h0000) begin
						cmd_nxt.orientation_cmd = 1'b0;
						cmd_nxt.rigid_tap_cycle = 1'b0;
						cmd_nxt.threading_cmd = 1'b0;
					end
				end
				ssp_pkg::OFS_STATUS: begin
					if (pwdata[ssp_pkg::STAT_REFUSED_BIT]) begin
						refused_nxt = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// a new refusal wins over a clear in the same cycle
		if (refuse_ev) begin
			refused_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_r <= '0;
			cmd_r <= '0;
			for (int i = 0; i < 4; i++) begin
				range_max_r[i] <= ssp_pkg::RANGE_RST;
			end
			resid_lvl_r <= ssp_pkg::RESID_LVL_RST;
			osc_code_r <= ssp_pkg::OSC_RST;
			enc_lines_r <= ssp_pkg::ENC_RST;
			prog_speed_r <= 14'h0000;
			refused_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			cmd_r <= cmd_nxt;
			range_max_r <= range_max_nxt;
			resid_lvl_r <= resid_lvl_nxt;
			osc_code_r <= osc_code_nxt;
			enc_lines_r <= enc_lines_nxt;
			prog_speed_r <= prog_speed_nxt;
			refused_r <= refused_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// speed limited by the selected gear range
	logic [13:0] range_lim;
	logic [13:0] speed_eff;
	logic coded_mode;
	logic closed_req;
	assign range_lim = range_max_r[cmd_r.range_sel];
	assign speed_eff = (prog_speed_r > range_lim) ? range_lim : prog_speed_r;
	assign coded_mode = ctrl_r.two_digit_code_enable |
		ctrl_r.four_digit_code_enable;
	// orient and tap run closed loop only with an encoder fitted
	assign closed_req = (cmd_r.orientation_cmd | cmd_r.rigid_tap_cycle) &
		(enc_lines_r != 14'h0000);

	// half-millisecond tick, strobe, stage and oscillation timers
	logic [15:0] pre_r, pre_nxt;
	logic tick;
	logic [8:0] strobe_cnt_r, strobe_cnt_nxt;
	logic [8:0] stage_cnt_r, stage_cnt_nxt;
	logic stage2_r, stage2_nxt; // second 4-digit stage shown
	logic [11:0] osc_cnt_r, osc_cnt_nxt;
	logic osc_neg_r, osc_neg_nxt;
	logic [11:0] osc_half;
	assign tick = (pre_r == 16'(TICK_CYC - 1));
	assign osc_half = 12'(osc_code_r * ssp_pkg::OSC_HALF_TICKS);

	always_comb begin
		pre_nxt = tick ? 16'h0000 : pre_r + 16'h0001;
		strobe_cnt_nxt = strobe_cnt_r;
		stage_cnt_nxt = stage_cnt_r;
		stage2_nxt = stage2_r;
		osc_cnt_nxt = osc_cnt_r;
		osc_neg_nxt = osc_neg_r;
		if (new_speed) begin
			// coded modes always strobe, analog only when enabled
			if (ctrl_r.speed_change_strobe_enable | coded_mode) begin
				strobe_cnt_nxt = 9'(ssp_pkg::STROBE_TICKS);
			end
			stage_cnt_nxt = 9'(ssp_pkg::STAGE_TICKS);
			stage2_nxt = 1'b0;
		end else if (tick) begin
			if (strobe_cnt_r != 9'h000) begin
				strobe_cnt_nxt = strobe_cnt_r - 9'h001;
			end
			if (stage_cnt_r != 9'h000) begin
				stage_cnt_nxt = stage_cnt_r - 9'h001;
				stage2_nxt = (stage_cnt_r == 9'h001);
			end
		end
		// codes 0 and 1 hold one direction; others toggle each half
		if (!cmd_r.range_change || osc_code_r < 8'h02) begin
			osc_cnt_nxt = 12'h000;
			osc_neg_nxt = (osc_code_r == 8'h01);
		end else if (tick) begin
			if (osc_cnt_r >= osc_half - 12'h001) begin
				osc_cnt_nxt = 12'h000;
				osc_neg_nxt = ~osc_neg_r;
			end else begin
				osc_cnt_nxt = osc_cnt_r + 12'h001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pre_r <= 16'h0000;
			strobe_cnt_r <= 9'h000;
			stage_cnt_r <= 9'h000;
			stage2_r <= 1'b0;
			osc_cnt_r <= 12'h000;
			osc_neg_r <= 1'b0;
		end else begin
			pre_r <= pre_nxt;
			strobe_cnt_r <= strobe_cnt_nxt;
			stage_cnt_r <= stage_cnt_nxt;
			stage2_r <= stage2_nxt;
			osc_cnt_r <= osc_cnt_nxt;
			osc_neg_r <= osc_neg_nxt;
		end
	end

	// quadrature decode, position count and windowed pulse rate
	logic a_r, b_r;
	logic [15:0] win_pulses_r, win_pulses_nxt;
	logic [15:0] rate_r, rate_nxt; // edges in last 10 ms window
	logic [4:0] win_cnt_r, win_cnt_nxt;
	logic step, up;
	assign step = (enc_a ^ a_r) | (enc_b ^ b_r);
	// a leading b counts up; the direction bit swaps that sense
	assign up = ((enc_a ^ b_r) ^ ctrl_r.count_direction_select);

	always_comb begin
		pos_nxt = pos_r;
		win_pulses_nxt = win_pulses_r;
		rate_nxt = rate_r;
		win_cnt_nxt = win_cnt_r;
		if (step) begin
			pos_nxt = up ? pos_r + 16'h0001 : pos_r - 16'h0001;
			win_pulses_nxt = win_pulses_r + 16'h0001;
		end
		if (tick) begin
			if (win_cnt_r == 5'(ssp_pkg::WINDOW_TICKS - 1)) begin
				win_cnt_nxt = 5'h00;
				rate_nxt = win_pulses_nxt;
				win_pulses_nxt = 16'h0000;
			end else begin
				win_cnt_nxt = win_cnt_r + 5'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			a_r <= 1'b0;
			b_r <= 1'b0;
			pos_r <= 16'h0000;
			win_pulses_r <= 16'h0000;
			rate_r <= 16'h0000;
			win_cnt_r <= 5'h00;
		end else begin
			a_r <= enc_a;
			b_r <= enc_b;
			pos_r <= pos_nxt;
			win_pulses_r <= win_pulses_nxt;
			rate_r <= rate_nxt;
			win_cnt_r <= win_cnt_nxt;
		end
	end

	// serial divider: level = speed * full scale / range limit
	logic [4:0] div_cnt_r, div_cnt_nxt;
	logic [25:0] num_r, num_nxt;
	logic [14:0] rem_r, rem_nxt;
	logic [25:0] quo_r, quo_nxt;
	logic [11:0] run_lvl_r, run_lvl_nxt;
	logic signed [12:0] trim_r, trim_nxt;
	logic [14:0] rem_sh;
	logic [31:0] meas_ppm, want_ppm;
	assign rem_sh = {rem_r[13:0], num_r[25]};
	assign meas_ppm = rate_r * 32'(ssp_pkg::WINDOWS_PER_MIN);
	// x4 decode gives four edges per encoder line
	assign want_ppm = speed_eff * enc_lines_r * 32'd4;

	always_comb begin
		div_cnt_nxt = div_cnt_r + 5'h01;
		num_nxt = {num_r[24:0], 1'b0};
		rem_nxt = rem_sh;
		quo_nxt = {quo_r[24:0], 1'b0};
		run_lvl_nxt = run_lvl_r;
		trim_nxt = trim_r;
		// compare first so the last quotient bit reaches the level
		if (div_cnt_r != 5'd0 && rem_sh >= {1'b0, range_lim}) begin
			rem_nxt = rem_sh - {1'b0, range_lim};
			quo_nxt[0] = 1'b1;
		end
		if (div_cnt_r == 5'd0) begin
			// restarts forever; a new speed settles within two passes
			num_nxt = 26'(speed_eff) * ssp_pkg::DRIVE_FULL;
			rem_nxt = 15'h0000;
			quo_nxt = 26'h0;
		end else if (div_cnt_r == 5'd26) begin
			div_cnt_nxt = 5'd0;
			run_lvl_nxt = (range_lim == 14'h0000) ? 12'h000 :
				quo_nxt[11:0];
		end
		// closed loop nudges drive once per window toward target
		if (!closed_req) begin
			trim_nxt = 13'sh0000;
		end else if (tick && win_cnt_r == 5'h00) begin
			if (meas_ppm < want_ppm && trim_r < 13'sd2047) begin
				trim_nxt = trim_r + 13'sd1;
			end else if (meas_ppm > want_ppm && trim_r > -13'sd2047) begin
				trim_nxt = trim_r - 13'sd1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			div_cnt_r <= 5'd0;
			num_r <= 26'h0;
			rem_r <= 15'h0000;
			quo_r <= 26'h0;
			run_lvl_r <= 12'h000;
			trim_r <= 13'sh0000;
		end else begin
			div_cnt_r <= div_cnt_nxt;
			num_r <= num_nxt;
			rem_r <= rem_nxt;
			quo_r <= quo_nxt;
			run_lvl_r <= run_lvl_nxt;
			trim_r <= trim_nxt;
		end
	end

	// speed to two-digit code through the range table
	function automatic logic [7:0] two_digit(input logic [13:0] s);
		logic [6:0] n;
		n = 7'd39;
		for (int i = 0; i < 60; i++) begin
			if (s >= ssp_pkg::BOUND[i]) begin
				n = n + 7'd1;
			end
		end
		if (s < 14'd10) begin
			return ssp_pkg::LOW_CODE[s[3:0]];
		end
		return {4'(n / 7'd10), 4'(n % 7'd10)};
	endfunction

	// binary speed to four 8-4-2-1 digits
	function automatic logic [15:0] four_digit(input logic [13:0] s);
		logic [15:0] d;
		d = 16'h0000;
		for (int i = 13; i >= 0; i--) begin
			for (int k = 0; k < 4; k++) begin
				if (d[k*4 +: 4] > 4'd4) begin
					d[k*4 +: 4] = d[k*4 +: 4] + 4'd3;
				end
			end
			d = {d[14:0], s[i]};
		end
		return d;
	endfunction

	// output stage: drive code, coded lines, strobe, loop flag
	logic signed [15:0] drive_nxt;
	logic [7:0] bcd_nxt;
	logic [15:0] digits;
	logic [12:0] mag;
	logic neg;
	logic signed [13:0] sum;
	assign digits = four_digit(prog_speed_r);
	assign sum = $signed({2'b00, run_lvl_r}) + 14'(trim_r);

	always_comb begin
		mag = 13'h0000;
		neg = 1'b0;
		if (cmd_r.range_change) begin
			// range change: residual level or none, oscillating sign
			mag = ctrl_r.residual_drive_enable ?
				{5'h00, resid_lvl_r} : 13'h0000;
			neg = osc_neg_r;
		end else if (cmd_r.spin_clockwise_cmd |
			cmd_r.spin_counterclockwise_cmd | closed_req) begin
			mag = (sum < 14'sd0) ? 13'h0000 :
				(sum > 14'sd4000) ? 13'd4000 : sum[12:0];
			neg = cmd_r.spin_counterclockwise_cmd &
				~ctrl_r.unipolar_select;
		end
		neg = neg ^ ctrl_r.drive_sign_select;
		if (coded_mode) begin
			mag = 13'h0000; // analog idle while coded output in use
		end
		drive_nxt = neg ? -$signed({3'b000, mag}) : $signed({3'b000, mag});
		bcd_nxt = 8'h00;
		if (ctrl_r.two_digit_code_enable) begin
			bcd_nxt = two_digit(prog_speed_r);
		end else if (ctrl_r.four_digit_code_enable) begin
			// upper nibble hundreds then units, lower thousands then tens
			bcd_nxt = stage2_r ? {digits[3:0], digits[7:4]} :
				{digits[11:8], digits[15:12]};
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			drive_code <= 16'sh0000;
			bcd_lines <= 8'h00;
			speed_strobe <= 1'b0;
			closed_loop <= 1'b0;
		end else begin
			drive_code <= drive_nxt;
			bcd_lines <= bcd_nxt;
			speed_strobe <= (strobe_cnt_r != 9'h000);
			closed_loop <= closed_req;
		end
	end

	assign status = {4'h0, osc_neg_r, refused_r, closed_loop, speed_strobe,
		bcd_lines, drive_code};
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
endmodule // ssp_spindle_out
`default_nettype wire

// [ssp_spindle_out_asserts.sv]
`default_nettype none
module ssp_spindle_out_chk #(
	parameter int TICK_CYC = 10
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic signed [15:0] drive_code,
	input wire logic [7:0] bcd_lines,
	input wire logic speed_strobe,
	input wire logic closed_loop
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	localparam int S1 = 199 * TICK_CYC; // still first stage
	localparam int S2 = 2 + 201 * TICK_CYC; // surely second stage
	logic wr, sw, sen, f4; // taken write, speed write, strobe due
	ssp_pkg::ssp_ctrl_s c_r; // shadow of the config word
	logic cw_r, ccw_r, rc_r, enc0_r;
	logic [7:0] lvl_r, osc_r;
	logic [13:0] spd_r; // clamped speed shadow
	logic [15:0] age_r, wcnt_r; // cycles since any write, since strobed speed write
	assign wr = psel && penable && pready && pwrite;
	assign sw = wr && paddr == ssp_pkg::OFS_SPEED;
	assign sen = c_r.speed_change_strobe_enable || c_r.two_digit_code_enable
		|| c_r.four_digit_code_enable;
	assign f4 = c_r.four_digit_code_enable && !c_r.two_digit_code_enable;
	// shadows follow only taken writes, as the register file does
	always_ff @(posedge clk) begin
		if (srst) begin
			c_r <= '0;
			{cw_r, ccw_r, rc_r, enc0_r} <= 4'h1;
			lvl_r <= 8'h01;
			osc_r <= 8'h00;
			spd_r <= '0;
			age_r <= '0;
			wcnt_r <= 16'hffff;
		end else begin
			// counters saturate so old history never wraps into a match
			if (age_r != 16'hffff) age_r <= age_r + 16'h0001;
			if (wr) age_r <= '0;
			if (wcnt_r != 16'hffff) wcnt_r <= wcnt_r + 16'h0001;
			if (sw && sen) wcnt_r <= '0;
			if (wr) begin
				case (paddr)
					ssp_pkg::OFS_CTRL: c_r <= ssp_pkg::ssp_ctrl_s'(pwdata[6:0]);
					ssp_pkg::OFS_RESID: {osc_r, lvl_r} <= pwdata[15:0];
					ssp_pkg::OFS_ENC: enc0_r <= pwdata[13:0] == 14'h0000;
					ssp_pkg::OFS_SPEED: spd_r <= pwdata[15:0] > 16'd9999 ?
						ssp_pkg::SPEED_MAX : pwdata[13:0];
					ssp_pkg::OFS_CMD: {rc_r, ccw_r, cw_r} <= {pwdata[5], pwdata[1:0]};
					default: ;
				endcase
			end
		end
	end
	property p_ready;
		psel && penable && !$past(penable) |-> pready ##1 !pready;
	endproperty
	a_ready: assert property (p_ready) else $error("pready not one cycle");
	property p_slverr;
		pready |-> pslverr == (paddr > 8'h28 || paddr[1:0] != 2'h0);
	endproperty
	a_slverr: assert property (p_slverr) else $error("bad pslverr");
	property p_strobe_src;
		$rose(speed_strobe) |-> $past(sw, 2) && $past(sen, 2);
	endproperty
	a_strobe_src: assert property (p_strobe_src) else $error("stray strobe");
	property p_strobe_len;
		$fell(speed_strobe) |-> wcnt_r >= 16'(2 + 399 * TICK_CYC)
			&& wcnt_r <= 16'(2 + 401 * TICK_CYC);
	endproperty
	a_strobe_len: assert property (p_strobe_len) else $error("strobe width");
	property p_stage;
		f4 && wcnt_r > 16'h0002 && wcnt_r <= 16'(S1) |->
			bcd_lines == {4'(spd_r / 100 % 10), 4'(spd_r / 1000)};
	endproperty
	a_stage: assert property (p_stage) else $error("first stage wrong");
	property p_stage2;
		f4 && wcnt_r == 16'(S2) |->
			bcd_lines == {4'(spd_r % 10), 4'(spd_r / 10 % 10)};
	endproperty
	a_stage2: assert property (p_stage2) else $error("second stage wrong");
	property p_coded;
		(c_r.two_digit_code_enable || c_r.four_digit_code_enable)
			&& age_r > 16'd40 |-> drive_code == 16'sd0;
	endproperty
	a_coded: assert property (p_coded) else $error("drive in coded mode");
	property p_uni;
		c_r.unipolar_select && !c_r.drive_sign_select && !rc_r && !closed_loop
			&& age_r > 16'd40 |-> drive_code >= 16'sd0;
	endproperty
	a_uni: assert property (p_uni) else $error("unipolar went negative");
	property p_sign;
		!c_r.unipolar_select && ccw_r && !cw_r && !rc_r && !closed_loop
			&& spd_r > 14'd10 && age_r > 16'd40 |->
			(drive_code < 16'sd0) == !c_r.drive_sign_select;
	endproperty
	a_sign: assert property (p_sign) else $error("drive sign wrong");
	property p_resid;
		rc_r && !c_r.drive_sign_select && osc_r < 8'h02 && age_r > 16'd40 |->
			drive_code == (!c_r.residual_drive_enable ? 16'sd0 :
			osc_r[0] ? -$signed({8'h00, lvl_r}) : $signed({8'h00, lvl_r}));
	endproperty
	a_resid: assert property (p_resid) else $error("residual drive wrong");
	property p_open;
		enc0_r && age_r > 16'd3 |-> !closed_loop;
	endproperty
	a_open: assert property (p_open) else $error("closed loop w/o encoder");
	c_strobe: cover property ($rose(speed_strobe));
	c_closed: cover property ($rose(closed_loop));
	c_err: cover property (pready && pslverr);
endmodule // ssp_spindle_out_chk
bind ssp_spindle_out ssp_spindle_out_chk #(.TICK_CYC(TICK_CYC)) i_chk (
	.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b), .drive_code(drive_code),
	.bcd_lines(bcd_lines), .speed_strobe(speed_strobe),
	.closed_loop(closed_loop));
`default_nettype wire

// [ssp_drive_model.sv]
`default_nettype none
// drive cabinet: turns while drive is nonzero, encoder reports motion
module ssp_drive_model #(
	parameter int STEP = 4 // cycles per encoder edge
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic signed [15:0] drive_code,
	output logic enc_a,
	output logic enc_b
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph_r; // quadrature phase
	logic [7:0] div_r; // speed divider, fixed rate keeps it simple
	always_ff @(posedge clk) begin
		if (srst) begin
			ph_r <= '0;
			div_r <= '0;
		end else if (drive_code != 16'sd0) begin
			div_r <= div_r + 8'h01;
			if (div_r == 8'(STEP - 1)) begin
				div_r <= '0;
				ph_r <= drive_code > 16'sd0 ? ph_r + 2'h1 : ph_r - 2'h1;
			end
		end
	end
	// positive drive: a leads b
	always_comb begin
		enc_a = ph_r[1] ^ ph_r[0];
		enc_b = ph_r[1];
	end
endmodule // ssp_drive_model
`default_nettype wire

// [tb.sv]
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int T = 10; // shortened tick
	logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rv;
	logic pready, pslverr, slv, enc_a, enc_b, speed_strobe, closed_loop;
	logic signed [15:0] drive_code;
	logic [7:0] bcd_lines;
	int failures = 0, comparisons = 0, cycles = 0, v, n, lvl;
	logic [15:0] p;
	logic prev;
	// reset values: address, expected
	logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
		8'h1c, 8'h20};
	logic [31:0] rx [9] = '{32'h0, 32'h270f, 32'h270f, 32'h270f, 32'h270f,
		32'h1, 32'h0, 32'h0, 32'h0};
	// two-digit corners: speed, code
	int sp [12] = '{0, 1, 2, 9, 10, 11, 12, 99, 100, 8999, 9000, 12000};
	logic [7:0] cd [12] = '{8'h00, 8'h20, 8'h26, 8'h39, 8'h40, 8'h40, 8'h41,
		8'h59, 8'h60, 8'h98, 8'h99, 8'h99};
	always #5 clk = ~clk;
	ssp_spindle_out #(.TICK_CYC(T)) i_dut (.clk(clk), .srst(srst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.enc_a(enc_a), .enc_b(enc_b), .drive_code(drive_code),
		.bcd_lines(bcd_lines), .speed_strobe(speed_strobe),
		.closed_loop(closed_loop));
	ssp_drive_model i_drv (.clk(clk), .srst(srst), .drive_code(drive_code),
		.enc_a(enc_a), .enc_b(enc_b));
	task automatic conclude();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// hang guard, well above the expected run
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			conclude();
		end
	end
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one apb transfer; request held until pready seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rv = prdata;
		slv = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [7:0] a, input int d);
		apb(1, a, 32'(d));
	endtask
	task automatic rd(input logic [7:0] a);
		apb(0, a, 32'h0);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task automatic strobe_wait();
		n = 0;
		while (speed_strobe === 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
	endtask
	// expected drive from speed, limit and polarity bits
	function automatic logic [31:0] dexp(int s, int lim, bit ccw, bit sg,
		bit uni);
		int d;
		bit neg;
		d = (s < lim ? s : lim) * 4000 / lim;
		neg = ccw && !uni;
		if (sg) neg = !neg;
		return 32'(neg ? -d : d);
	endfunction
	// four-digit stages, low nibble first digit
	function automatic logic [7:0] st(int s, bit two);
		if (two) return {4'(s % 10), 4'(s / 10 % 10)};
		return {4'(s / 100 % 10), 4'(s / 1000)};
	endfunction
	initial begin
		void'($urandom(32'h4610));
		repeat (20) @(posedge clk);
		srst <= 0;
		for (int i = 0; i < 9; i++) begin
			rd(ra[i]);
			check(rv, rx[i]);
		end
		rd(8'h80); // unmapped place
		check({rv[30:0], slv}, 32'h1);
		// range limits clamp, then unused ranges back to top speed
		for (int i = 0; i < 4; i++) begin
			v = $urandom_range(16383);
			wr(8'h04 + 8'(4 * i), v);
			rd(8'h04 + 8'(4 * i));
			check(rv, 32'(v > 9999 ? 9999 : v));
			wr(8'h04 + 8'(4 * i), 9999);
		end
		wr(8'h1c, 12000);
		rd(8'h1c);
		check(rv, 32'h270f);
		// two-digit coded output, corners of the range table
		wr(8'h00, 32'h10);
		for (int i = 0; i < 12; i++) begin
			wr(8'h1c, sp[i]);
			cyc(3);
			check(bcd_lines, cd[i]);
		end
		check(speed_strobe, 1);
		cyc(40);
		check(drive_code, 0);
		// four-digit coded output, two stages
		wr(8'h00, 32'h20);
		for (int k = 0; k < 3; k++) begin
			v = k == 0 ? 9999 : $urandom_range(9999);
			wr(8'h1c, v);
			cyc(3);
			check(bcd_lines, st(v, 0));
			check(speed_strobe, 1);
			cyc(201 * T);
			check(bcd_lines, st(v, 1));
			strobe_wait();
			v = n + 3 + 201 * T;
			check(32'(v >= 398 * T && v <= 402 * T), 1);
		end
		check(drive_code, 0);
		// strobe option off, then on
		wr(8'h00, 0);
		wr(8'h1c, 100);
		cyc(3);
		check(speed_strobe, 0);
		wr(8'h00, 8);
		wr(8'h1c, 200);
		cyc(3);
		check(speed_strobe, 1);
		strobe_wait();
		// polarity: every sign, type and direction combination
		for (int m = 0; m < 8; m++) begin
			v = $urandom_range(100, 9999);
			wr(8'h00, {m[1], m[0], 1'b0});
			wr(8'h20, m[2] ? 2 : 1);
			wr(8'h1c, v);
			cyc(60);
			check(drive_code, dexp(v, 9999, m[2], m[0], m[1]));
		end
		// second range limit scales the drive
		wr(8'h08, 2000);
		wr(8'h20, 32'h41);
		wr(8'h1c, 3000);
		cyc(60);
		check(drive_code, dexp(3000, 2000, 0, 1, 1));
		wr(8'h1c, 1000);
		cyc(60);
		check(drive_code, dexp(1000, 2000, 0, 1, 1));
		// range change: residual level, steady and oscillating
		lvl = $urandom_range(1, 255);
		wr(8'h00, 1);
		wr(8'h20, 32'h20);
		for (int o = 0; o < 2; o++) begin
			wr(8'h14, (o << 8) | lvl);
			cyc(40);
			check(drive_code, 32'(o ? -lvl : lvl));
		end
		wr(8'h00, 0);
		cyc(40);
		check(drive_code, 0);
		wr(8'h00, 1);
		foreach (sp[i]) if (sp[i] == 2 || sp[i] == 10) begin
			wr(8'h14, (sp[i] << 8) | lvl);
			n = 0;
			prev = drive_code < 0;
			repeat (2000) begin
				@(posedge clk);
				if ((drive_code < 0) != prev) n++;
				prev = drive_code < 0;
			end
			v = 2000 / (sp[i] * 10 * T);
			check(32'(n >= v - 1 && n <= v + 1), 1);
		end
		// no encoder: refused, open loop, refusal flag clears
		wr(8'h20, 0);
		wr(8'h18, 0);
		wr(8'h20, 32'h04);
		rd(8'h20);
		check(rv, 0);
		rd(8'h24);
		check(32'(rv[26]), 1);
		check(closed_loop, 0);
		wr(8'h24, 32'h0400_0000);
		rd(8'h24);
		check(32'(rv[26]), 0);
		wr(8'h18, 500);
		wr(8'h20, 32'h04);
		cyc(3);
		check(closed_loop, 1);
		// counting sense follows the direction bit
		wr(8'h20, 1);
		wr(8'h1c, 5000);
		for (int d = 0; d < 2; d++) begin
			wr(8'h00, d << 6);
			cyc(40);
			rd(8'h28);
			p = rv[15:0];
			cyc(200);
			rd(8'h28);
			p = rv[15:0] - p;
			check(32'(($signed(p) > 0) == (d == 0)), 1);
		end
		conclude();
	end
endmodule // tb
`default_nettype wire
